// ### lewdt_pkg.sv
// Package for the low-energy watchdog: register map, control field layout,
// reset values, sync timing and the enumerations shared by its two modules.
// Assumes a single core clock and oscillator ticks sampled on that clock.
`default_nettype none
package lewdt_pkg;
  // Register byte offsets, one aligned 32-bit word each
  localparam logic [11:0] LEWDT_OFF_CTRL = 12'h000;
  localparam logic [11:0] LEWDT_OFF_CMD = 12'h004;
  localparam logic [11:0] LEWDT_OFF_SYNC = 12'h008;
  localparam logic [11:0] LEWDT_OFF_COUNT = 12'h00c;
  localparam int LEWDT_ADDR_W = 12;

  // Control word width and field positions
  localparam int LEWDT_CTRL_W = 12;
  localparam int LEWDT_PER_W = 4;
  localparam int LEWDT_CNT_W = 19;
  localparam int LEWDT_CMD_CLEAR_BIT = 0;
  localparam int LEWDT_SYNC_CTRL_BIT = 0;
  localparam int LEWDT_SYNC_CMD_BIT = 1;
  localparam logic [11:0] LEWDT_CTRL_RESET = 12'h000;

  // Timeout is 2^(base + period_select) + 1 ticks
  localparam int LEWDT_PER_BASE = 3;
  localparam logic [LEWDT_CNT_W-1:0] LEWDT_PER_EXTRA = 19'h00001;

  // Ticks of the watchdog clock needed to move a write across
  localparam logic [1:0] LEWDT_SYNC_TICKS = 2'h2;

  // AXI response codes
  localparam logic [1:0] LEWDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] LEWDT_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LEWDT_SRC_LFRC = 2'b00,
    LEWDT_SRC_LOW_FREQ_CRYSTAL = 2'b01,
    LEWDT_SRC_ULRC = 2'b10,
    LEWDT_SRC_NONE = 2'b11
  } lewdt_src_e;

  typedef enum logic [2:0] {
    LEWDT_PS_ACTIVE = 3'b000,
    LEWDT_PS_SLEEP = 3'b001,
    LEWDT_PS_DEEP = 3'b010,
    LEWDT_PS_STOP = 3'b011,
    LEWDT_PS_SHUTOFF = 3'b100
  } lewdt_pstate_e;

  // Control word, bit 0 is the enable
  typedef struct packed {
    lewdt_src_e clock_source_select;
    logic [LEWDT_PER_W-1:0] period_select;
    logic osc_disable_guard;
    logic shutoff_entry_block;
    logic run_in_stop;
    logic run_in_deep_sleep;
    logic run_when_halted;
    logic enable;
  } lewdt_ctrl_s;
endpackage
`default_nettype wire

// ### lewdt_counter.sv
// Watchdog count core: counts selected-clock ticks up to the timeout.
// Assumes the parent gates run with the freeze conditions and the tick.
`timescale 1ns/10ps
`default_nettype none
module lewdt_counter
  import lewdt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wipe,
  input wire logic clear,
  input wire logic run,
  input wire logic [LEWDT_PER_W-1:0] period_select,
  output logic [LEWDT_CNT_W-1:0] count,
  output logic expire
);
  logic [LEWDT_CNT_W-1:0] limit;
  logic at_limit;

  // Timeout length in ticks for the current period
  assign limit = (LEWDT_PER_EXTRA << (LEWDT_PER_BASE + int'(period_select))) + LEWDT_PER_EXTRA;
  assign at_limit = (count == limit - LEWDT_PER_EXTRA);

  // Freezing simply withholds run, so the held value is kept
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= run && at_limit && !wipe && !clear;
      if (wipe || clear) begin
        count <= '0;
      end else if (run) begin
        count <= at_limit ? '0 : count + LEWDT_PER_EXTRA;
      end
    end
  end
endmodule
`default_nettype wire

// ### lewdt_top.sv
// Low-energy watchdog top: AXI4-Lite registers, write synchronisation into
// the watchdog tick domain, freeze control and power-state blocking.
// Assumes osc_tick pulses are one core cycle wide and synchronous to core_clk.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lewdt_top
  import lewdt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [LEWDT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [LEWDT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] osc_tick,
  input wire logic debug_halted,
  input wire logic [2:0] power_state,
  output logic [2:0] osc_hold_on,
  output logic block_stop_entry,
  output logic block_shutoff_entry,
  output logic reset_request
);
  // Tick of the oscillator named by a source select code
  function automatic logic pick_tick(input logic [2:0] ticks, input lewdt_src_e sel);
    logic t;
    t = 1'b0;
    case (sel)
      LEWDT_SRC_LFRC: t = ticks[0];
      LEWDT_SRC_LOW_FREQ_CRYSTAL: t = ticks[1];
      LEWDT_SRC_ULRC: t = ticks[2];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  lewdt_ctrl_s ctrl_shadow;
  lewdt_ctrl_s ctrl_live;
  logic ctrl_pending;
  logic cmd_pending;
  logic [1:0] ctrl_sync_cnt;
  logic [1:0] cmd_sync_cnt;
  logic aw_full;
  logic w_full;
  logic [LEWDT_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [LEWDT_CNT_W-1:0] count;
  logic expire;

  // Write channel: address and data may arrive in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_full || aw_take;
  wire w_have = w_full || w_take;
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  wire next_aw_full = aw_have && !do_write;
  wire next_w_full = w_have && !do_write;

  // Address decode for writes
  wire wr_ctrl = do_write && (aw_addr == LEWDT_OFF_CTRL);
  wire wr_cmd = do_write && (aw_addr == LEWDT_OFF_CMD);
  wire wr_known = (aw_addr == LEWDT_OFF_CTRL) || (aw_addr == LEWDT_OFF_CMD) ||
                  (aw_addr == LEWDT_OFF_SYNC) || (aw_addr == LEWDT_OFF_COUNT);
  wire [31:0] ctrl_merged = lane_merge({20'h00000, ctrl_shadow}, w_data, w_strb);
  wire lewdt_ctrl_s ctrl_new = lewdt_ctrl_s'(ctrl_merged[LEWDT_CTRL_W-1:0]);
  wire wr_clear = wr_cmd && w_strb[0] && w_data[LEWDT_CMD_CLEAR_BIT];
  wire wr_disable = wr_ctrl && !ctrl_new.enable;

  // Read channel decode
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] sync_word = {30'h0, cmd_pending, ctrl_pending};
  wire [31:0] count_word = {13'h0, count};
  wire rd_ctrl = (s_axi_araddr == LEWDT_OFF_CTRL);
  wire rd_cmd = (s_axi_araddr == LEWDT_OFF_CMD);
  wire rd_sync = (s_axi_araddr == LEWDT_OFF_SYNC);
  wire rd_count = (s_axi_araddr == LEWDT_OFF_COUNT);
  wire [31:0] rd_word = rd_ctrl ? {20'h00000, ctrl_shadow} :
                        rd_sync ? sync_word :
                        rd_count ? count_word : 32'h00000000;
  wire [1:0] rd_resp = (rd_ctrl || rd_cmd || rd_sync || rd_count) ?
                       LEWDT_RESP_OKAY : LEWDT_RESP_SLVERR;

  // Ticks: a pending control write crosses on the newly chosen clock
  wire live_tick = pick_tick(osc_tick, ctrl_live.clock_source_select);
  wire shadow_tick = pick_tick(osc_tick, ctrl_shadow.clock_source_select);
  wire ctrl_done = ctrl_pending && shadow_tick && (ctrl_sync_cnt == LEWDT_SYNC_TICKS - 2'h1);
  wire cmd_done = cmd_pending && live_tick && (cmd_sync_cnt == LEWDT_SYNC_TICKS - 2'h1);
  wire clr_fire = cmd_done && ctrl_live.enable && !wr_disable;

  // Freeze conditions; active and sleep are not distinguished
  wire ps_deep = (power_state == LEWDT_PS_DEEP);
  wire ps_stop = (power_state == LEWDT_PS_STOP);
  wire ps_off = (power_state == LEWDT_PS_SHUTOFF);
  wire halt_frz = debug_halted && !ctrl_live.run_when_halted;
  wire deep_frz = ps_deep && !ctrl_live.run_in_deep_sleep;
  wire stop_frz = ps_stop && !ctrl_live.run_in_stop;
  wire run_ok = ctrl_live.enable && !ps_off && !halt_frz && !deep_frz && !stop_frz;
  wire cnt_run = run_ok && live_tick;
  wire cnt_wipe = !ctrl_live.enable || wr_disable;

  // Blocking outputs derived from the applied control word
  wire src_lf = (ctrl_live.clock_source_select == LEWDT_SRC_LFRC) ||
                (ctrl_live.clock_source_select == LEWDT_SRC_LOW_FREQ_CRYSTAL);
  wire src_ul = (ctrl_live.clock_source_select == LEWDT_SRC_ULRC);
  wire guard_on = ctrl_live.enable && ctrl_live.osc_disable_guard;
  wire next_block_stop = guard_on && src_lf;
  wire next_block_off = ctrl_live.enable && (ctrl_live.shutoff_entry_block || (guard_on && src_ul));
  wire [2:0] next_hold = guard_on ? (3'h1 << ctrl_live.clock_source_select) & 3'h7 : 3'h0;

  lewdt_counter u_counter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wipe(cnt_wipe),
    .clear(clr_fire),
    .run(cnt_run),
    .period_select(ctrl_live.period_select),
    .count(count),
    .expire(expire)
  );

  // AXI write channel handshake state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LEWDT_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= wr_known ? LEWDT_RESP_OKAY : LEWDT_RESP_SLVERR;
      end
    end
  end

  // AXI read channel, data registered one cycle after the address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= LEWDT_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // Control write crossing; disabling acts at once and drops pending work
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_shadow <= lewdt_ctrl_s'(LEWDT_CTRL_RESET);
      ctrl_live <= lewdt_ctrl_s'(LEWDT_CTRL_RESET);
      ctrl_pending <= 1'b0;
      ctrl_sync_cnt <= '0;
    end else if (wr_disable) begin
      ctrl_shadow <= ctrl_new;
      ctrl_live <= ctrl_new;
      ctrl_pending <= 1'b0;
      ctrl_sync_cnt <= '0;
    end else if (wr_ctrl) begin
      ctrl_shadow <= ctrl_new;
      ctrl_pending <= 1'b1;
      ctrl_sync_cnt <= '0;
    end else if (ctrl_done) begin
      ctrl_live <= ctrl_shadow;
      ctrl_pending <= 1'b0;
      ctrl_sync_cnt <= '0;
    end else if (ctrl_pending && shadow_tick) begin
      ctrl_sync_cnt <= ctrl_sync_cnt + 2'h1;
    end
  end

  // Clear command crossing; a new clear write wins over completion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_pending <= 1'b0;
      cmd_sync_cnt <= '0;
    end else if (wr_disable || !ctrl_live.enable) begin
      cmd_pending <= 1'b0;
      cmd_sync_cnt <= '0;
    end else if (wr_clear) begin
      cmd_pending <= 1'b1;
      cmd_sync_cnt <= '0;
    end else if (cmd_done) begin
      cmd_pending <= 1'b0;
      cmd_sync_cnt <= '0;
    end else if (cmd_pending && live_tick) begin
      cmd_sync_cnt <= cmd_sync_cnt + 2'h1;
    end
  end

  // Power and reset outputs; the reset request holds until system reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_hold_on <= 3'h0;
      block_stop_entry <= 1'b0;
      block_shutoff_entry <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      osc_hold_on <= next_hold;
      block_stop_entry <= next_block_stop;
      block_shutoff_entry <= next_block_off;
      if (expire) begin
        reset_request <= 1'b1;
      end
    end
  end

  // A timeout raises the reset request on the next edge
  AST_TIMEOUT_RESET: assert property (@(posedge core_clk) disable iff (!reset_n)
    expire |=> reset_request)
    else $error("Timeout did not raise reset request");

  // A timeout happens only from the last count of the period
  AST_PERIOD_LENGTH: assert property (@(posedge core_clk) disable iff (!reset_n)
    expire |-> $past(count) == ((LEWDT_PER_EXTRA << (LEWDT_PER_BASE +
      int'($past(ctrl_live.period_select)))) ))
    else $error("Timeout not at two to the power of period plus one ticks");

  // A synchronised clear leaves the count at zero
  // A clear written in the completing cycle starts a fresh crossing
  AST_CLEAR_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
    clr_fire |=> (count == '0) && (!cmd_pending || $past(wr_clear)))
    else $error("Clear command did not zero the count");

  // Disabling aborts pending syncs and resets the count
  AST_DISABLE_ABORT: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_disable |=> !ctrl_pending && !cmd_pending && (count == '0) && !ctrl_live.enable)
    else $error("Disable did not reset the watchdog");

  // An enabling control write is still pending, and not yet applied, on the next cycle
  AST_SYNC_PENDING: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wr_ctrl && !wr_disable) |=> ctrl_pending && (ctrl_live == $past(ctrl_live)))
    else $error("Control write applied without synchronisation");

  // Count is held in shutoff
  AST_SHUTOFF_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ps_off && !clr_fire && !cnt_wipe) |=> $stable(count))
    else $error("Counter moved in shutoff");

  // Debug halt without run permission freezes the count
  AST_HALT_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (halt_frz && !clr_fire && !cnt_wipe) |=> $stable(count))
    else $error("Counter moved during debug halt");

  // Deep sleep or stop without run permission freezes the count
  AST_LOWPOWER_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((deep_frz || stop_frz) && !clr_fire && !cnt_wipe) |=> $stable(count))
    else $error("Counter moved in a frozen low-power state");

  // Resumed counting steps on from the held value
  // Below the period's last count every run tick adds exactly one
  AST_RESUME_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cnt_run && !clr_fire && !cnt_wipe &&
      (count != (LEWDT_PER_EXTRA << (LEWDT_PER_BASE + int'(ctrl_live.period_select))))) |=>
      (count == $past(count) + LEWDT_PER_EXTRA))
    else $error("Counter did not continue from held value");

  // Guard with a low-frequency source blocks stop entry
  AST_STOP_BLOCK: assert property (@(posedge core_clk) disable iff (!reset_n)
    (guard_on && src_lf) |=> block_stop_entry)
    else $error("Stop entry not blocked");

  // Shutoff block bit or guard on ultra-low RC blocks shutoff entry
  AST_SHUTOFF_BLOCK: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_live.enable && (ctrl_live.shutoff_entry_block || (guard_on && src_ul)))
      |=> block_shutoff_entry)
    else $error("Shutoff entry not blocked");

  // Guard holds exactly the selected oscillator on
  AST_OSC_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (guard_on && (src_lf || src_ul)) |=>
      $onehot(osc_hold_on) && osc_hold_on[$past(ctrl_live.clock_source_select)])
    else $error("Selected oscillator not held on");

  // Without the guard no oscillator is held on
  AST_OSC_RELEASE: assert property (@(posedge core_clk) disable iff (!reset_n)
    !guard_on |=> (osc_hold_on == 3'h0))
    else $error("Oscillator held on without the guard");
endmodule
`default_nettype wire

// ### lewdt_tb.sv
// Self-checking bench for the low-energy watchdog top, driven over AXI4-Lite.
// Assumes oscillator ticks are one-cycle pulses on core_clk, as the top expects.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lewdt_pkg::*;
  logic core_clk, reset_n;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] osc_tick, power_state, osc_hold_on;
  logic debug_halted, block_stop_entry, block_shutoff_entry, reset_request;
  int fails = 0;
  int tests_run = 0;

  lewdt_top dut (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_tick(osc_tick), .debug_halted(debug_halted),
    .power_state(power_state), .osc_hold_on(osc_hold_on),
    .block_stop_entry(block_stop_entry), .block_shutoff_entry(block_shutoff_entry),
    .reset_request(reset_request));

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A used-up bound counts as a mismatch and closes the run
  task automatic bound(input int n);
    if (n >= 60) begin
      fails++;
      $display("CHECK FAILED at %0t: handshake wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done) && n < 60) begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bound(n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!bvalid && n < 60);
    bound(n);
    r = bresp;
    bready <= 1'b0;
    // One idle edge so a following call never re-raises bready in this step
    @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!arready && n < 60);
    bound(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rvalid && n < 60);
    bound(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic expect_reg(input logic [11:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(d, e, what);
    chk({30'h0, r}, {30'h0, LEWDT_RESP_OKAY}, "read response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk({30'h0, r}, {30'h0, LEWDT_RESP_OKAY}, "write response");
  endtask

  // One-cycle tick pulses, then let the count land
  task automatic tick(input logic [2:0] m, input int k);
    repeat (k) begin
      osc_tick <= m;
      @(posedge core_clk);
      osc_tick <= 3'h0;
      @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    debug_halted <= 1'b0;
    power_state <= 3'h0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Enable write, then two ticks of the chosen source carry it across
  task automatic enable_with(input lewdt_ctrl_s c);
    wr(LEWDT_OFF_CTRL, {20'h0, c});
    expect_reg(LEWDT_OFF_SYNC, 32'h1, "control sync pending");
    tick(3'h1 << c.clock_source_select, 2);
    expect_reg(LEWDT_OFF_SYNC, 32'h0, "control sync done");
  endtask

  task automatic t_registers();
    logic [31:0] d;
    logic [1:0] r;
    do_reset();
    expect_reg(LEWDT_OFF_CTRL, 32'h0, "control reset value");
    expect_reg(LEWDT_OFF_COUNT, 32'h0, "count reset value");
    expect_reg(LEWDT_OFF_CMD, 32'h0, "command reads zero");
    wr(LEWDT_OFF_CTRL, 32'hfffff001);
    expect_reg(LEWDT_OFF_CTRL, 32'h1, "upper control bits read zero");
    tick(3'h1, 2);
    expect_reg(LEWDT_OFF_SYNC, 32'h0, "enable applied");
    wr(LEWDT_OFF_CMD, 32'h1);
    // Only byte lane 1 written: enable in lane 0 must survive
    wstrb <= 4'h2;
    wr(LEWDT_OFF_CTRL, 32'h00000302);
    wstrb <= 4'hf;
    expect_reg(LEWDT_OFF_CTRL, 32'h301, "byte strobes honoured");
    axi_write(12'h010, 32'h1, r);
    chk({30'h0, r}, {30'h0, LEWDT_RESP_SLVERR}, "unmapped write response");
    axi_read(12'h010, d, r);
    chk({30'h0, r}, {30'h0, LEWDT_RESP_SLVERR}, "unmapped read response");
    chk(d, 32'h0, "unmapped read data");
    $display("Test registers done");
  endtask

  // Every period value used here times out at 2^(3+p)+1 ticks
  task automatic t_timeout();
    lewdt_ctrl_s c;
    for (int p = 0; p < 2; p++) begin
      do_reset();
      c = '0;
      c.enable = 1'b1;
      c.period_select = 4'(p);
      enable_with(c);
      tick(3'h1, (1 << (3 + p)));
      expect_reg(LEWDT_OFF_COUNT, 32'(1 << (3 + p)), "count before timeout");
      chk({31'h0, reset_request}, 32'h0, "no reset before timeout");
      tick(3'h1, 1);
      chk({31'h0, reset_request}, 32'h1, "reset request at timeout");
      expect_reg(LEWDT_OFF_COUNT, 32'h0, "count wraps at timeout");
    end
    $display("Test timeout done");
  endtask

  // Pass 0 freezes in halt, deep and stop; pass 1 runs there; shutoff never runs
  task automatic t_freeze();
    lewdt_ctrl_s c;
    int e;
    for (int p = 0; p < 2; p++) begin
      do_reset();
      c = '0;
      c.enable = 1'b1;
      c.period_select = 4'h4;
      c.run_when_halted = 1'(p);
      c.run_in_deep_sleep = 1'(p);
      c.run_in_stop = 1'(p);
      enable_with(c);
      e = 0;
      for (int k = 0; k < 5; k++) begin
        debug_halted <= (k == 0);
        power_state <= (k == 1) ? 3'h2 : (k == 2) ? 3'h3 : (k == 3) ? 3'h4 : 3'h1;
        tick(3'h1, 1);
        e += (k == 4) ? 1 : (k == 3) ? 0 : p;
        expect_reg(LEWDT_OFF_COUNT, 32'(e), "count in state");
        debug_halted <= 1'b0;
        power_state <= 3'h0;
        tick(3'h1, 1);
        e++;
        expect_reg(LEWDT_OFF_COUNT, 32'(e), "count resumes");
      end
    end
    $display("Test freeze done");
  endtask

  // Halt frozen during the clear sync so the zeroing is exact
  task automatic t_clear();
    lewdt_ctrl_s c;
    do_reset();
    c = '0;
    c.enable = 1'b1;
    c.period_select = 4'h4;
    enable_with(c);
    tick(3'h1, 5);
    debug_halted <= 1'b1;
    wr(LEWDT_OFF_CMD, 32'h1);
    expect_reg(LEWDT_OFF_SYNC, 32'h2, "clear sync pending");
    tick(3'h1, 2);
    expect_reg(LEWDT_OFF_COUNT, 32'h0, "count cleared");
    debug_halted <= 1'b0;
    tick(3'h1, 1);
    expect_reg(LEWDT_OFF_COUNT, 32'h1, "count after clear");
    $display("Test clear done");
  endtask

  // Each source in turn: only its ticks count, and the guard outputs follow it
  task automatic t_sources();
    lewdt_ctrl_s c;
    for (int s = 0; s < 3; s++) begin
      do_reset();
      c = '0;
      c.enable = 1'b1;
      c.period_select = 4'h4;
      c.osc_disable_guard = 1'b1;
      c.shutoff_entry_block = (s == 1);
      c.clock_source_select = lewdt_src_e'(s);
      enable_with(c);
      tick(~(3'h1 << s), 2);
      tick(3'h1 << s, 1);
      expect_reg(LEWDT_OFF_COUNT, 32'h1, "count from selected source");
      chk({29'h0, osc_hold_on}, 32'(1 << s), "oscillator hold");
      chk({31'h0, block_stop_entry}, 32'(s != 2), "stop entry block");
      chk({31'h0, block_shutoff_entry}, 32'(s != 0), "shutoff entry block");
    end
    $display("Test sources done");
  endtask

  task automatic t_disable();
    lewdt_ctrl_s c;
    do_reset();
    c = '0;
    c.enable = 1'b1;
    c.period_select = 4'h4;
    c.osc_disable_guard = 1'b1;
    enable_with(c);
    tick(3'h1, 3);
    expect_reg(LEWDT_OFF_COUNT, 32'h3, "count before disable");
    chk({29'h0, osc_hold_on}, 32'h1, "hold before disable");
    wr(LEWDT_OFF_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    expect_reg(LEWDT_OFF_COUNT, 32'h0, "count reset by disable");
    chk({29'h0, osc_hold_on}, 32'h0, "hold released by disable");
    wr(LEWDT_OFF_CTRL, 32'h1);
    wr(LEWDT_OFF_CTRL, 32'h0);
    expect_reg(LEWDT_OFF_SYNC, 32'h0, "pending sync aborted");
    $display("Test disable done");
  endtask

  initial begin
    reset_n = 1'b0;
    awaddr = 12'h0;
    araddr = 12'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    osc_tick = 3'h0;
    power_state = 3'h0;
    debug_halted = 1'b0;
    t_registers();
    t_timeout();
    t_freeze();
    t_clear();
    t_sources();
    t_disable();
    tally_and_finish();
  end
endmodule
`default_nettype wire
